/* File: hdl/flash_front_pkg.sv */
// Constants, register map and state types of the serial flash read and protect front end.
// Assumes a single system clock; the serial link is sampled, not clocked.
package flash_front_pkg;

  // ---------------------------------------------------------------
  // Register map (plain port, 4-bit byte address)
  // ---------------------------------------------------------------
  localparam logic [3:0] REG_STATUS   = 4'h0;
  localparam logic [3:0] REG_CTRL     = 4'h4;
  localparam logic [3:0] REG_MEM_ADDR = 4'h8;
  localparam logic [3:0] REG_MEM_DATA = 4'hC;

  // ---------------------------------------------------------------
  // Status byte layout
  // ---------------------------------------------------------------
  localparam int          BIT_BUSY      = 0;
  localparam int          BIT_LATCH     = 1;
  localparam int          BIT_QUAD      = 6;
  localparam int          BIT_LOCK      = 7;
  localparam logic [7:0]  STATUS_RESET  = 8'h00;
  localparam logic [7:0]  STATUS_WMASK  = 8'hFC;
  localparam int          BIT_CTRL_BUSY = 0;

  // ---------------------------------------------------------------
  // Opcodes
  // ---------------------------------------------------------------
  localparam logic [7:0] OP_WRITE_UNLOCK = 8'h06;
  localparam logic [7:0] OP_WRITE_RELOCK = 8'h04;
  localparam logic [7:0] OP_STATUS_READ  = 8'h05;
  localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
  localparam logic [7:0] OP_READ         = 8'h03;
  localparam logic [7:0] OP_FAST_READ    = 8'h0B;
  localparam logic [7:0] OP_SINGLE_DTR   = 8'h0D;
  localparam logic [7:0] OP_DUAL_IO      = 8'hBB;
  localparam logic [7:0] OP_DUAL_DTR     = 8'hBD;
  localparam logic [7:0] OP_QUAD_IO      = 8'hEB;

  // ---------------------------------------------------------------
  // Phase lengths
  // ---------------------------------------------------------------
  localparam logic [4:0] CMD_BITS    = 5'h08;
  localparam logic [4:0] ADDR_BITS   = 5'h18;
  localparam logic [4:0] MODE_BITS   = 5'h08;
  localparam logic [3:0] DUMMY_FAST  = 4'h8;
  localparam logic [3:0] DUMMY_SDTR  = 4'h6;
  localparam logic [3:0] DUMMY_DUAL  = 4'h4;
  localparam logic [3:0] DUMMY_DDTR  = 4'h6;
  localparam logic [3:0] DUMMY_QUAD  = 4'h4;
  localparam logic [2:0] LANES_1     = 3'h1;
  localparam logic [2:0] LANES_2     = 3'h2;
  localparam logic [2:0] LANES_4     = 3'h4;
  localparam logic [3:0] OE_N_NONE   = 4'hF;
  localparam logic [3:0] OE_N_SINGLE = 4'hD;
  localparam logic [3:0] OE_N_DUAL   = 4'hC;
  localparam logic [3:0] OE_N_QUAD   = 4'h0;
  localparam logic [5:0] SYNC_RESET  = 6'h20;

  typedef enum logic [3:0] {
    ST_IDLE, ST_CMD, ST_ADDR, ST_MODE, ST_DUMMY, ST_DATA, ST_STATUS_IN, ST_SKIP
  } phase_t;

  typedef enum logic [3:0] {
    K_NONE, K_READ, K_FAST, K_SDTR, K_DUAL, K_DDTR, K_QUAD, K_STATUS_RD, K_STATUS_WR
  } kind_t;

endpackage : flash_front_pkg

/* File: hdl/pin_sync.sv */
// Two-stage synchroniser for a group of pin levels.
// Assumes the pins are unrelated to clk_sys; each bit is treated alone.
`timescale 1ns/1ps
module pin_sync #(
  parameter int               WIDTH   = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input  wire logic             clk_sys,
  input  wire logic             resetn,
  input  wire logic [WIDTH-1:0] pins,
  output logic      [WIDTH-1:0] pins_s
);

  logic [WIDTH-1:0] stage1_ff;
  logic [WIDTH-1:0] stage2_ff;

  // ---------------------------------------------------------------
  // First stage feeds only the second
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      stage1_ff <= RST_VAL;
      stage2_ff <= RST_VAL;
    end else begin
      stage1_ff <= pins;
      stage2_ff <= stage1_ff;
    end
  end

  assign pins_s = stage2_ff;

endmodule : pin_sync

/* File: hdl/flash_read_protect.sv */
// Serial flash command front end: protection modes and array read commands.
// Assumes sclk is slow enough (period of 8 clk_sys or more) to be oversampled.
`timescale 1ns/1ps
// Behaviour
// - Lock clear: unlock and status changes allowed
// - Lock set, pin high: changes still allowed
// - Lock set and pin low: hard protect
// - Hard protect ends with pin high, or lock cleared or quad set
// - Quad enable disables hard protect
// - Basic read: sample rise, drive fall
// - Any start address, increment, wrap zero
// - Fast read: one dummy byte
// - Busy rejects fast, DTR, dual, quad commands, not enhanced-mode quad frames
// - Single DTR: bit on each edge
// - Single DTR: 6 dummy clocks
// - Dual I/O: two lines, 4 dummy
// - Dual/quad move later phases wide
// - Dual DTR: 4 bits per clock
// - Quad I/O: four lines, 4 dummy
// - Complementary nibbles keep enhanced mode
// - Status write refused in hard protect
// - Quad enable stored, pin protect off
module flash_read_protect
  import flash_front_pkg::*;
#(
  parameter int MEM_AW = 8
) (
  input  wire logic       clk_sys,
  input  wire logic       resetn,
  input  wire logic       cs_n,
  input  wire logic       sclk,
  input  wire logic       data_line_0_i,
  output logic            data_line_0_o,
  output logic            data_line_0_oe_n,
  input  wire logic       data_line_1_i,
  output logic            data_line_1_o,
  output logic            data_line_1_oe_n,
  input  wire logic       protect_pin_io2_i,
  output logic            protect_pin_io2_o,
  output logic            protect_pin_io2_oe_n,
  input  wire logic       data_line_3_i,
  output logic            data_line_3_o,
  output logic            data_line_3_oe_n,
  input  wire logic [3:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  output logic            hard_protect_mode
);

  localparam int MEM_DEPTH = 1 << MEM_AW;

  // ---------------------------------------------------------------
  // Pin synchronisation and clock edges
  // ---------------------------------------------------------------
  logic [5:0] pins_s;
  logic       cs_s;
  logic       sclk_s;
  logic [3:0] io_s;
  logic       sclk_d_ff;
  logic       rise_ev;
  logic       fall_ev;

  pin_sync #(.WIDTH(6), .RST_VAL(SYNC_RESET)) u_sync (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .pins    ({cs_n, sclk, data_line_3_i, protect_pin_io2_i, data_line_1_i, data_line_0_i}),
    .pins_s  (pins_s)
  );

  assign cs_s    = pins_s[5];
  assign sclk_s  = pins_s[4];
  assign io_s    = pins_s[3:0];
  assign rise_ev = sclk_s & ~sclk_d_ff;
  assign fall_ev = ~sclk_s & sclk_d_ff;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      sclk_d_ff <= 1'b0;
    end else begin
      sclk_d_ff <= sclk_s;
    end
  end

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  phase_t            state_ff,  nxt_state;
  kind_t             kind_ff,   nxt_kind;
  logic [4:0]        cnt_ff,    nxt_cnt;
  logic [23:0]       shift_ff,  nxt_shift;
  logic [MEM_AW-1:0] addr_ff,   nxt_addr;
  logic [2:0]        lanes_ff,  nxt_lanes;
  logic              dtr_ff,    nxt_dtr;
  logic [3:0]        dummy_ff,  nxt_dummy;
  logic [7:0]        obyte_ff,  nxt_obyte;
  logic [2:0]        ocnt_ff,   nxt_ocnt;
  logic [3:0]        dout_ff,   nxt_dout;
  logic [3:0]        oe_n_ff,   nxt_oe_n;
  logic              enh_ff,    nxt_enh;
  logic [7:0]        status_ff, nxt_status;
  logic              busy_ff,   nxt_busy;
  logic [MEM_AW-1:0] maddr_ff,  nxt_maddr;
  logic [7:0]        rdata_ff,  nxt_rdata;
  logic              hpm_ff,    nxt_hpm;
  logic [7:0]        mem_ff [MEM_DEPTH];
  logic [7:0]        nxt_mem [MEM_DEPTH];

  logic       in_ev;
  logic       out_ev;
  logic [3:0] in_bits;
  logic [7:0] opcode;
  logic [4:0] cnt_step;
  logic [7:0] cur_byte;
  logic       set_latch;
  logic       clr_latch;
  logic       status_go;
  logic       hpm_now;

  assign opcode   = {shift_ff[6:0], io_s[0]};
  assign in_ev    = rise_ev | (dtr_ff & fall_ev);
  assign out_ev   = fall_ev | (dtr_ff & rise_ev);
  assign cnt_step = {2'b00, lanes_ff};
  // Protect pin level counts only while the quad enable bit (BIT_QUAD) is clear
  assign hpm_now  = status_ff[BIT_LOCK] & ~io_s[2] & ~status_ff[BIT_QUAD];

  always_comb begin
    case (lanes_ff)
      LANES_2: in_bits = {2'b00, io_s[1:0]};
      LANES_4: in_bits = io_s;
      default: in_bits = {3'b000, io_s[0]};
    endcase
  end

  // ---------------------------------------------------------------
  // Serial command engine
  // ---------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    nxt_kind  = kind_ff;
    nxt_cnt   = cnt_ff;
    nxt_shift = shift_ff;
    nxt_addr  = addr_ff;
    nxt_lanes = lanes_ff;
    nxt_dtr   = dtr_ff;
    nxt_dummy = dummy_ff;
    nxt_obyte = obyte_ff;
    nxt_ocnt  = ocnt_ff;
    nxt_dout  = dout_ff;
    nxt_oe_n  = oe_n_ff;
    nxt_enh   = enh_ff;
    set_latch = 1'b0;
    clr_latch = 1'b0;
    status_go = 1'b0;
    cur_byte  = (kind_ff == K_STATUS_RD && ocnt_ff == '0) ? {status_ff[7:1], busy_ff} : obyte_ff;
    if (cs_s) begin
      // Partial commands are dropped; only a whole status byte is kept
      status_go = (state_ff == ST_STATUS_IN) && (cnt_ff == CMD_BITS);
      nxt_state = ST_IDLE;
      nxt_oe_n  = OE_N_NONE;
      nxt_dtr   = 1'b0;
    end else begin
      case (state_ff)
        ST_IDLE: begin
          nxt_cnt   = '0;
          nxt_shift = '0;
          if (enh_ff) begin
            nxt_state = ST_ADDR;
            nxt_kind  = K_QUAD;
            nxt_lanes = LANES_4;
          end else begin
            nxt_state = ST_CMD;
            nxt_kind  = K_NONE;
            nxt_lanes = LANES_1;
          end
        end
        ST_CMD: begin
          if (rise_ev) begin
            nxt_shift = {shift_ff[22:0], io_s[0]};
            nxt_cnt   = cnt_ff + 5'h01;
            if (cnt_ff == CMD_BITS - 5'h01) begin
              nxt_cnt   = '0;
              nxt_state = ST_ADDR;
              case (opcode)
                OP_READ:       nxt_kind = K_READ;
                OP_FAST_READ:  nxt_kind = K_FAST;
                OP_SINGLE_DTR: begin
                  nxt_kind = K_SDTR;
                  nxt_dtr  = 1'b1;
                end
                OP_DUAL_IO: begin
                  nxt_kind  = K_DUAL;
                  nxt_lanes = LANES_2;
                end
                OP_DUAL_DTR: begin
                  nxt_kind  = K_DUAL_DTR_KIND();
                  nxt_lanes = LANES_2;
                  nxt_dtr   = 1'b1;
                end
                OP_QUAD_IO: begin
                  nxt_kind  = K_QUAD;
                  nxt_lanes = LANES_4;
                end
                OP_STATUS_READ: begin
                  nxt_kind  = K_STATUS_RD;
                  nxt_state = ST_DATA;
                  nxt_ocnt  = '0;
                end
                OP_STATUS_WRITE: begin
                  nxt_kind  = K_STATUS_WR;
                  nxt_state = ST_STATUS_IN;
                end
                OP_WRITE_UNLOCK: begin
                  set_latch = 1'b1;
                  nxt_state = ST_SKIP;
                end
                OP_WRITE_RELOCK: begin
                  clr_latch = 1'b1;
                  nxt_state = ST_SKIP;
                end
                default: nxt_state = ST_SKIP;
              endcase
              if (busy_ff && (opcode == OP_FAST_READ || opcode == OP_SINGLE_DTR
                  || opcode == OP_DUAL_IO || opcode == OP_DUAL_DTR || opcode == OP_QUAD_IO)) begin
                nxt_state = ST_SKIP;
                nxt_lanes = LANES_1;
                nxt_dtr   = 1'b0;
              end
            end
          end
        end
        ST_ADDR: begin
          if (in_ev) begin
            nxt_shift = (shift_ff << lanes_ff) | {20'h00000, in_bits};
            nxt_cnt   = cnt_ff + cnt_step;
            if (cnt_ff + cnt_step == ADDR_BITS) begin
              nxt_addr = nxt_shift[MEM_AW-1:0];
              nxt_cnt  = '0;
              nxt_ocnt = '0;
              case (kind_ff)
                K_READ: nxt_state = ST_DATA;
                K_QUAD: nxt_state = ST_MODE;
                K_FAST: begin
                  nxt_state = ST_DUMMY;
                  nxt_dummy = DUMMY_FAST;
                end
                K_SDTR: begin
                  nxt_state = ST_DUMMY;
                  nxt_dummy = DUMMY_SDTR;
                end
                K_DUAL: begin
                  nxt_state = ST_DUMMY;
                  nxt_dummy = DUMMY_DUAL;
                end
                default: begin
                  nxt_state = ST_DUMMY;
                  nxt_dummy = DUMMY_DDTR;
                end
              endcase
            end
          end
        end
        ST_MODE: begin
          if (rise_ev) begin
            nxt_shift = {shift_ff[19:0], in_bits};
            nxt_cnt   = cnt_ff + cnt_step;
            if (cnt_ff + cnt_step == MODE_BITS) begin
              // Enhanced mode survives only complementary nibbles
              nxt_enh   = (nxt_shift[7:4] == ~nxt_shift[3:0]);
              nxt_state = ST_DUMMY;
              nxt_dummy = DUMMY_QUAD;
            end
          end
        end
        ST_DUMMY: begin
          if (rise_ev) begin
            nxt_dummy = dummy_ff - 4'h1;
            if (dummy_ff == 4'h1) begin
              nxt_state = ST_DATA;
            end
          end
        end
        ST_DATA: begin
          if (out_ev) begin
            if (ocnt_ff == 3'h0 && kind_ff != K_STATUS_RD) begin
              cur_byte = mem_ff[addr_ff];
              nxt_addr = addr_ff + MEM_AW'(1);
            end
            case (lanes_ff)
              LANES_2: begin
                nxt_dout = {2'b00, cur_byte[7:6]};
                nxt_oe_n = OE_N_DUAL;
                nxt_ocnt = (ocnt_ff == 3'h0) ? 3'h3 : ocnt_ff - 3'h1;
              end
              LANES_4: begin
                nxt_dout = cur_byte[7:4];
                nxt_oe_n = OE_N_QUAD;
                nxt_ocnt = (ocnt_ff == 3'h0) ? 3'h1 : ocnt_ff - 3'h1;
              end
              default: begin
                nxt_dout = {2'b00, cur_byte[7], 1'b0};
                nxt_oe_n = OE_N_SINGLE;
                nxt_ocnt = ocnt_ff - 3'h1;
              end
            endcase
            nxt_obyte = cur_byte << lanes_ff;
          end
        end
        ST_STATUS_IN: begin
          if (rise_ev && cnt_ff <= CMD_BITS) begin
            nxt_shift = {shift_ff[22:0], io_s[0]};
            nxt_cnt   = cnt_ff + 5'h01;
          end
        end
        default: nxt_state = state_ff;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Status, array and register port
  // ---------------------------------------------------------------
  always_comb begin
    nxt_status = status_ff;
    nxt_busy   = busy_ff;
    nxt_maddr  = maddr_ff;
    nxt_rdata  = '0;
    nxt_hpm    = hpm_now;
    nxt_mem    = mem_ff;
    if (reg_wr) begin
      case (reg_addr)
        REG_STATUS:   nxt_status = (status_ff & ~STATUS_WMASK) | (reg_wdata & STATUS_WMASK);
        REG_CTRL:     nxt_busy   = reg_wdata[BIT_CTRL_BUSY];
        REG_MEM_ADDR: nxt_maddr  = reg_wdata[MEM_AW-1:0];
        REG_MEM_DATA: begin
          nxt_mem[maddr_ff] = reg_wdata;
          nxt_maddr         = maddr_ff + MEM_AW'(1);
        end
        default: nxt_busy = busy_ff;
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        REG_STATUS:   nxt_rdata = {status_ff[7:1], busy_ff};
        REG_CTRL:     nxt_rdata = {7'h00, busy_ff};
        REG_MEM_ADDR: nxt_rdata = 8'(maddr_ff);
        REG_MEM_DATA: nxt_rdata = mem_ff[maddr_ff];
        default:      nxt_rdata = '0;
      endcase
    end
    // Serial commands win over a register write in the same cycle
    if (status_go && status_ff[BIT_LATCH] && !busy_ff) begin
      if (!hpm_ff) begin
        nxt_status = (status_ff & ~STATUS_WMASK) | (shift_ff[7:0] & STATUS_WMASK);
        nxt_status[BIT_LATCH] = 1'b0;
      end
    end
    if (clr_latch) begin
      nxt_status[BIT_LATCH] = 1'b0;
    end
    if (set_latch) begin
      nxt_status[BIT_LATCH] = 1'b1;
    end
    nxt_status[BIT_BUSY] = 1'b0;
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state_ff  <= ST_IDLE;
      kind_ff   <= K_NONE;
      cnt_ff    <= '0;
      shift_ff  <= '0;
      addr_ff   <= '0;
      lanes_ff  <= LANES_1;
      dtr_ff    <= 1'b0;
      dummy_ff  <= '0;
      obyte_ff  <= '0;
      ocnt_ff   <= '0;
      dout_ff   <= '0;
      oe_n_ff   <= OE_N_NONE;
      enh_ff    <= 1'b0;
      status_ff <= STATUS_RESET;
      busy_ff   <= 1'b0;
      maddr_ff  <= '0;
      rdata_ff  <= '0;
      hpm_ff    <= 1'b0;
      for (int i = 0; i < MEM_DEPTH; i++) begin
        mem_ff[i] <= '0;
      end
    end else begin
      state_ff  <= nxt_state;
      kind_ff   <= nxt_kind;
      cnt_ff    <= nxt_cnt;
      shift_ff  <= nxt_shift;
      addr_ff   <= nxt_addr;
      lanes_ff  <= nxt_lanes;
      dtr_ff    <= nxt_dtr;
      dummy_ff  <= nxt_dummy;
      obyte_ff  <= nxt_obyte;
      ocnt_ff   <= nxt_ocnt;
      dout_ff   <= nxt_dout;
      oe_n_ff   <= nxt_oe_n;
      enh_ff    <= nxt_enh;
      status_ff <= nxt_status;
      busy_ff   <= nxt_busy;
      maddr_ff  <= nxt_maddr;
      rdata_ff  <= nxt_rdata;
      hpm_ff    <= nxt_hpm;
      mem_ff    <= nxt_mem;
    end
  end

  assign data_line_0_o        = dout_ff[0];
  assign data_line_1_o        = dout_ff[1];
  assign protect_pin_io2_o    = dout_ff[2];
  assign data_line_3_o        = dout_ff[3];
  assign data_line_0_oe_n     = oe_n_ff[0];
  assign data_line_1_oe_n     = oe_n_ff[1];
  assign protect_pin_io2_oe_n = oe_n_ff[2];
  assign data_line_3_oe_n     = oe_n_ff[3];
  assign reg_rdata            = rdata_ff;
  assign hard_protect_mode    = hpm_ff;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  property p_hpm_enter;
    @(posedge clk_sys) disable iff (!resetn)
      (status_ff[BIT_LOCK] && !io_s[2] && !status_ff[BIT_QUAD]) |=> hpm_ff;
  endproperty
  a_hpm_enter: assert property (p_hpm_enter) else $error("hard protect not entered");

  property p_quad_no_hpm;
    @(posedge clk_sys) disable iff (!resetn)
      status_ff[BIT_QUAD] |=> !hpm_ff;
  endproperty
  a_quad_no_hpm: assert property (p_quad_no_hpm) else $error("hard protect with quad");

  property p_hpm_exit;
    @(posedge clk_sys) disable iff (!resetn)
      (hpm_ff && io_s[2]) |=> !hpm_ff;
  endproperty
  a_hpm_exit: assert property (p_hpm_exit) else $error("hard protect held with pin high");

  property p_cs_release;
    @(posedge clk_sys) disable iff (!resetn)
      cs_s |=> (oe_n_ff == OE_N_NONE) && (state_ff == ST_IDLE);
  endproperty
  a_cs_release: assert property (p_cs_release) else $error("lines driven while deselected");

  property p_hpm_refuse;
    @(posedge clk_sys) disable iff (!resetn)
      (status_go && hpm_ff && !reg_wr) |=> $stable(status_ff[7:2]);
  endproperty
  a_hpm_refuse: assert property (p_hpm_refuse) else $error("status changed in hard protect");

  property p_unlock;
    @(posedge clk_sys) disable iff (!resetn)
      set_latch |=> status_ff[BIT_LATCH];
  endproperty
  a_unlock: assert property (p_unlock) else $error("write latch not set");

  property p_busy_reject;
    @(posedge clk_sys) disable iff (!resetn)
      (state_ff == ST_CMD && rise_ev && !cs_s && busy_ff && cnt_ff == CMD_BITS - 5'h01
       && opcode == OP_QUAD_IO) |=> (state_ff == ST_SKIP) ##1 (oe_n_ff == OE_N_NONE);
  endproperty
  a_busy_reject: assert property (p_busy_reject) else $error("read accepted while busy");

  property p_wrap;
    @(posedge clk_sys) disable iff (!resetn)
      (state_ff == ST_DATA && out_ev && !cs_s && ocnt_ff == 3'h0 && kind_ff != K_STATUS_RD
       && addr_ff == {MEM_AW{1'b1}}) |=> (addr_ff == '0);
  endproperty
  a_wrap: assert property (p_wrap) else $error("address did not wrap");

  property p_single_fall;
    @(posedge clk_sys) disable iff (!resetn)
      (!dtr_ff && $changed(dout_ff) && !$past(cs_s)) |-> $past(fall_ev);
  endproperty
  a_single_fall: assert property (p_single_fall) else $error("single data not on fall");

  function automatic kind_t K_DUAL_DTR_KIND();
    return K_DDTR;
  endfunction : K_DUAL_DTR_KIND

endmodule : flash_read_protect

/* File: sim/flash_host_model.sv */
// Host controller model: frames on cs_n, sclk and four data lines.
// Assumes clk_sys at 50 ns; sclk period is 8 clk_sys (400 ns), idle low.
`timescale 1ns/1ps
module flash_host_model (
  input  wire logic       clk_sys,
  input  wire logic       wp,
  input  wire logic [3:0] line,
  output logic            cs_n,
  output logic            sclk,
  output logic [3:0]      drv,
  output logic [3:0]      drv_en
);
  logic [3:0] d = 4'h0;
  logic [3:0] e = 4'h0;
  logic       quad = 1'b0;
  logic [7:0] rx[$];
  initial cs_n = 1'b1;
  initial sclk = 1'b0;
  // Board holds the protect level on line 2 outside quad frames
  assign drv    = {d[3], quad ? d[2] : wp, d[1:0]};
  assign drv_en = {e[3], quad ? e[2] : 1'b1, e[1:0]};
  // ------------------------------------------------------------
  // One frame
  // ------------------------------------------------------------
  task automatic clk_bit(input logic [3:0] en, input logic [3:0] v);
    e <= en;
    d <= v;
    repeat (4) @(posedge clk_sys);
    sclk <= 1'b1;
    repeat (4) @(posedge clk_sys);
    sclk <= 1'b0;
  endtask : clk_bit
  task automatic frame(input logic [7:0] op, input int lanes, input logic [31:0] adr,
                       input int abits, input int dummy, input int nbytes);
    logic [3:0] m;
    logic [7:0] b;
    m = 4'((1 << lanes) - 1);
    rx.delete();
    @(posedge clk_sys);
    quad <= (lanes == 4);
    cs_n <= 1'b0;
    // Opcode on line 0, then address and mode bits on the frame's lanes
    for (int i = 7; i >= 0 && op != 8'h00; i--) clk_bit(4'h1, {3'b000, op[i]});
    for (int i = abits - lanes; i >= 0; i -= lanes) clk_bit(m, 4'(adr >> i) & m);
    // Lines let go for the turnaround
    repeat (dummy) clk_bit(4'h0, 4'h0);
    repeat (nbytes) begin
      for (int j = 0; j < 8; j += lanes) begin
        repeat (4) @(posedge clk_sys);
        sclk <= 1'b1;
        // Sampled late in the high phase; the device answers a few clocks after the fall
        repeat (4) @(posedge clk_sys);
        b = (b << lanes) | 8'(lanes == 1 ? {3'b000, line[1]} : line & m);
        sclk <= 1'b0;
      end
      rx.push_back(b);
    end
    repeat (4) @(posedge clk_sys);
    cs_n <= 1'b1;
    e <= 4'h0;
    quad <= 1'b0;
    repeat (8) @(posedge clk_sys);
  endtask : frame
endmodule : flash_host_model

/* File: sim/serial_flash_read_protect_test.sv */
// Bench for the flash front end: register port, protect modes, read commands.
// Assumes flash_host_model on the link; double-rate reads are only tried while busy.
`timescale 1ns/1ps
module serial_flash_read_protect_test;
  import flash_front_pkg::*;
  logic            clk_sys = 1'b0;
  logic            resetn = 1'b0;
  logic [3:0]      reg_addr = 4'h0;
  logic [7:0]      reg_wdata = 8'h00;
  logic            reg_wr = 1'b0;
  logic            reg_rd = 1'b0;
  logic            wp = 1'b1;
  logic            tog = 1'b0;
  logic            drove = 1'b0;
  logic [7:0]      rd_val;
  int              n_mismatch = 0;
  int              compares = 0;
  int              cyc = 0;
  wire logic [7:0] reg_rdata;
  wire logic       hard_protect_mode;
  wire logic       cs_n;
  wire logic       sclk;
  wire logic [3:0] drv;
  wire logic [3:0] drv_en;
  wire logic [3:0] dev_o;
  wire logic [3:0] oe_n;
  wire logic [3:0] line;
  // Released lines toggle so a stale level never passes for data
  assign line = (~oe_n & dev_o) | (oe_n & drv_en & drv) | (oe_n & ~drv_en & {4{tog}});
  flash_read_protect uut (.clk_sys(clk_sys), .resetn(resetn), .cs_n(cs_n), .sclk(sclk),
    .data_line_0_i(line[0]), .data_line_0_o(dev_o[0]), .data_line_0_oe_n(oe_n[0]),
    .data_line_1_i(line[1]), .data_line_1_o(dev_o[1]), .data_line_1_oe_n(oe_n[1]),
    .protect_pin_io2_i(line[2]), .protect_pin_io2_o(dev_o[2]),
    .protect_pin_io2_oe_n(oe_n[2]),
    .data_line_3_i(line[3]), .data_line_3_o(dev_o[3]), .data_line_3_oe_n(oe_n[3]),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .hard_protect_mode(hard_protect_mode));
  flash_host_model host (.clk_sys(clk_sys), .wp(wp), .line(line), .cs_n(cs_n),
    .sclk(sclk), .drv(drv), .drv_en(drv_en));
  // ------------------------------------------------------------
  // Clock, watchdog and shared tasks
  // ------------------------------------------------------------
  initial forever #25 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    tog <= ~tog;
    cyc <= cyc + 1;
    if (!cs_n && oe_n != 4'hF) drove <= 1'b1;
    if (cyc == 40000) begin
      n_mismatch++;
      report_and_stop();
    end
  end
  function automatic logic [7:0] md(input logic [7:0] a);
    return a ^ 8'h96;
  endfunction : md
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 rd_val = reg_rdata;
  endtask : rd
  task automatic set_wp(input logic v);
    @(posedge clk_sys);
    wp <= v;
    repeat (8) @(posedge clk_sys);
  endtask : set_wp
  task automatic rd_frame(input logic [7:0] op, input int lanes, input logic [31:0] adr,
                          input int abits, input int dummy, input logic [7:0] a0);
    host.frame(op, lanes, adr, abits, dummy, 3);
    for (int i = 0; i < 3; i++) chk("read byte", md(8'(a0 + i)), host.rx[i]);
    chk("lines released", 8'h0F, 8'(oe_n));
  endtask : rd_frame
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_regs();
    rd(REG_STATUS);
    chk("status reset", STATUS_RESET, rd_val);
    rd(4'h2);
    chk("unmapped read", 8'h00, rd_val);
    wr(REG_STATUS, 8'hFF);
    rd(REG_STATUS);
    chk("status write", STATUS_WMASK, rd_val);
    wr(REG_STATUS, 8'h00);
    wr(REG_MEM_ADDR, 8'hFE);
    for (int i = 0; i < 6; i++) wr(REG_MEM_DATA, md(8'(8'hFE + i)));
  endtask : t_regs
  task automatic t_reads();
    rd_frame(OP_READ, 1, 32'hFE, 24, 0, 8'hFE);
    rd_frame(OP_FAST_READ, 1, 32'h01, 24, 8, 8'h01);
    rd_frame(OP_DUAL_IO, 2, 32'hFF, 24, 4, 8'hFF);
    wr(REG_STATUS, 8'h40);
    rd_frame(OP_QUAD_IO, 4, 32'h1A5, 32, 4, 8'h01);
    rd_frame(8'h00, 4, 32'h100, 32, 4, 8'h01);
    wr(REG_STATUS, 8'h00);
  endtask : t_reads
  task automatic t_busy();
    logic [7:0] ops[5] = '{OP_FAST_READ, OP_SINGLE_DTR, OP_DUAL_IO, OP_DUAL_DTR, OP_QUAD_IO};
    wr(REG_CTRL, 8'h01);
    foreach (ops[k]) begin
      drove = 1'b0;
      host.frame(ops[k], 1, 32'h0, 24, 8, 1);
      chk("drive while busy", 8'h00, 8'(drove));
    end
    wr(REG_CTRL, 8'h00);
  endtask : t_busy
  task automatic t_protect();
    wr(REG_STATUS, 8'hC0);
    set_wp(1'b0);
    chk("protect with quad", 8'h00, 8'(hard_protect_mode));
    wr(REG_STATUS, 8'h80);
    repeat (8) @(posedge clk_sys);
    chk("protect on", 8'h01, 8'(hard_protect_mode));
    host.frame(OP_WRITE_UNLOCK, 1, 32'h0, 0, 0, 0);
    host.frame(OP_STATUS_WRITE, 1, 32'h0, 8, 0, 0);
    rd(REG_STATUS);
    chk("status under protect", 8'h80, rd_val & 8'hFC);
    set_wp(1'b1);
    chk("protect off", 8'h00, 8'(hard_protect_mode));
    wr(REG_STATUS, 8'h80);
    host.frame(OP_WRITE_UNLOCK, 1, 32'h0, 0, 0, 0);
    rd(REG_STATUS);
    chk("latch set", 8'h82, rd_val);
    host.frame(OP_STATUS_WRITE, 1, 32'h0, 8, 0, 0);
    rd(REG_STATUS);
    chk("status changed", 8'h00, rd_val);
  endtask : t_protect
  task automatic report_and_stop();
    if (n_mismatch == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    repeat (2) @(posedge clk_sys);
    resetn <= 1'b1;
    repeat (3) @(posedge clk_sys);
    t_regs();
    t_reads();
    t_busy();
    t_protect();
    report_and_stop();
  end
endmodule : serial_flash_read_protect_test
